// ---- cspc_socket.sv ----
// Contract
// - force register bits 31..15, bit 6 and reserved bits read zero.
// - writing bit 14 reinterrogates card, refreshes present state, re-enables power control.
// - force bits 13..10 load voltage-support flags; a one disables power control; the code leaves it enabled when bit 14 is set in the same write.
// - force bit 9 writes the bad-supply-request flag.
// - bits 8 and 7 load data-loss and unrecognized-card flags.
// - bits 5 and 4 load cardbus and sixteen-bit detected flags.
// - bit 3 loads power event flag; power cycle status unchanged.
// - bits 2 and 1 load detect events; live detect levels unchanged.
// - bit 0 loads status-change event; live status level unchanged.
// - control bits 31..8 and bit 3 read zero.
// - policy zero: stop clock after 8 idle clocks and host stop request.
// - policy one: stop clock after 8 idle clocks regardless of host.
// - vcc field 6..4: 000 off, 010 5V, 011 3.3V, 100 XX, 101 YY.
// - vpp field 2..0: 000 off, 001 12V, 010 5V, 011 3.3V, 100, 101.
// - with cardbus card, power applied only at vcc levels the card supports.
// - bad-supply-request flag is one after an invalid power request.
`timescale 1ns/10ps
`default_nettype none
`include "cspc_cfg.svh"
module cspc_socket (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // card interrogation results and live pins
  input wire logic [3:0] card_volt_support_pin,
  input wire logic card_is_cardbus_pin,
  input wire logic card_is_sixteen_pin,
  input wire logic detect_one_pin,
  input wire logic detect_two_pin,
  input wire logic status_change_pin,
  input wire logic power_good_pin,
  // clock run
  input wire logic card_bus_idle,
  input wire logic host_clock_stop_req,
  output logic card_clock_stop_req,
  // socket power switch
  output logic [2:0] vcc_apply,
  output logic [2:0] vpp_apply,
  output logic interrogate_pulse
);
  logic [7:0] ctrl;
  logic [3:0] volt_flags;
  logic bad_supply_request_flag;
  logic data_loss_flag;
  logic unrecognized_card_flag;
  logic cardbus_detected_flag;
  logic sixteen_bit_detected_flag;
  logic power_event_flag;
  logic detect_two_event_flag;
  logic detect_one_event_flag;
  logic status_change_event_flag;
  logic power_ctl_en;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] card_s1;
  logic [5:0] card_s2;
  logic wr_force;
  logic wr_ctrl;
  logic rd_event;
  logic [2:0] wvcc;
  logic [2:0] wvpp;
  logic vcc_bad;
  logic vpp_bad;
  logic vcc_ok_for_card;
  logic [31:0] next_prdata;
  // clock-run controls and the stop request travel together to the idle tracker
  cspc_idle_if idl ();

  // pin inputs come from the socket domain: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
    end else begin
      pin_s1 <= {power_good_pin, status_change_pin, detect_two_pin, detect_one_pin, card_bus_idle,
                 host_clock_stop_req};
      pin_s2 <= pin_s1;
    end
  end

  // interrogation results settle long before software asks, but they still cross domains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_s1 <= 6'h00;
      card_s2 <= 6'h00;
    end else begin
      card_s1 <= {card_is_sixteen_pin, card_volt_support_pin, card_is_cardbus_pin};
      card_s2 <= card_s1;
    end
  end

  // the stop policy acts at once; only the pins pay the two-flop latency
  assign idl.policy = ctrl[`CSPC_C_STOP];
  assign idl.bus_idle = pin_s2[1];
  assign idl.host_stop_req = pin_s2[0];
  assign card_clock_stop_req = idl.stop_req;

  cspc_clkstop u_clkstop (
    .pclk(pclk),
    .presetn(presetn),
    .idl(idl)
  );

  // zero wait state slave; writes land at the access edge
  // unmapped addresses decode to nothing: writes vanish and reads give zero
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_force = psel && penable && pwrite && (paddr == `CSPC_OFF_FORCE);
  assign wr_ctrl = psel && penable && pwrite && (paddr == `CSPC_OFF_CTRL);
  assign rd_event = psel && penable && !pwrite && (paddr == `CSPC_OFF_EVENT);
  assign wvcc = pwdata[`CSPC_C_VCC_HI:`CSPC_C_VCC_LO];
  assign wvpp = pwdata[`CSPC_C_VPP_HI:`CSPC_C_VPP_LO];

  // reserved codes are spotted on the bus so a bad pair never reaches the switch
  always_comb begin
    vcc_bad = 1'b0;
    unique case (wvcc)
      cspc_pkg::CSPC_VCC_OFF, cspc_pkg::CSPC_VCC_5V0, cspc_pkg::CSPC_VCC_3V3,
      cspc_pkg::CSPC_VCC_XX, cspc_pkg::CSPC_VCC_YY: vcc_bad = 1'b0;
      default: vcc_bad = 1'b1;
    endcase
    vpp_bad = 1'b0;
    unique case (wvpp)
      cspc_pkg::CSPC_VPP_OFF, cspc_pkg::CSPC_VPP_12V, cspc_pkg::CSPC_VPP_5V0,
      cspc_pkg::CSPC_VPP_3V3, cspc_pkg::CSPC_VPP_XX, cspc_pkg::CSPC_VPP_YY: vpp_bad = 1'b0;
      default: vpp_bad = 1'b1;
    endcase
  end

  // requested vcc must be one the card claims to support
  always_comb begin
    vcc_ok_for_card = 1'b0;
    unique case (ctrl[`CSPC_C_VCC_HI:`CSPC_C_VCC_LO])
      cspc_pkg::CSPC_VCC_5V0: vcc_ok_for_card = volt_flags[0];
      cspc_pkg::CSPC_VCC_3V3: vcc_ok_for_card = volt_flags[1];
      cspc_pkg::CSPC_VCC_XX: vcc_ok_for_card = volt_flags[2];
      cspc_pkg::CSPC_VCC_YY: vcc_ok_for_card = volt_flags[3];
      default: vcc_ok_for_card = 1'b0;
    endcase
  end

  // control register; bad codes are stored as off so power stays down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CSPC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl[`CSPC_C_STOP] <= pwdata[`CSPC_C_STOP];
      // bit 3 is reserved and kept at zero
      ctrl[3] <= 1'b0;
      ctrl[`CSPC_C_VCC_HI:`CSPC_C_VCC_LO] <= (vcc_bad || vpp_bad) ? 3'h0 : wvcc;
      ctrl[`CSPC_C_VPP_HI:`CSPC_C_VPP_LO] <= (vcc_bad || vpp_bad) ? 3'h0 : wvpp;
    end
  end

  // when power control is disabled by a forced flag, the switch is held off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcc_apply <= 3'h0;
      vpp_apply <= 3'h0;
    end else if (!power_ctl_en || (cardbus_detected_flag && !vcc_ok_for_card)) begin
      vcc_apply <= 3'h0;
      vpp_apply <= 3'h0;
    end else begin
      vcc_apply <= ctrl[`CSPC_C_VCC_HI:`CSPC_C_VCC_LO];
      vpp_apply <= ctrl[`CSPC_C_VPP_HI:`CSPC_C_VPP_LO];
    end
  end

  // forced support flags mean the card was never really asked, so automatic power stays parked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ctl_en <= 1'b1;
    end else if (wr_force && pwdata[`CSPC_F_REINT]) begin
      power_ctl_en <= 1'b1;
    end else if (wr_force && (pwdata[`CSPC_F_YY:`CSPC_F_HIGH] != 4'h0)) begin
      power_ctl_en <= 1'b0;
    end
  end

  // one-cycle strobe to the interrogation sequencer; every write with the bit set restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrogate_pulse <= 1'b0;
    end else begin
      interrogate_pulse <= wr_force && pwdata[`CSPC_F_REINT];
    end
  end

  // support flags: a refresh ors the card's answer with any forced bit in the same write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_flags <= 4'h0;
    end else if (wr_force && pwdata[`CSPC_F_REINT]) begin
      volt_flags <= card_s2[4:1] | pwdata[`CSPC_F_YY:`CSPC_F_HIGH];
    end else if (wr_force) begin
      volt_flags <= pwdata[`CSPC_F_YY:`CSPC_F_HIGH];
    end
  end

  // card kind: only a refresh or a force write moves these, never a live pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cardbus_detected_flag <= 1'b0;
      sixteen_bit_detected_flag <= 1'b0;
    end else if (wr_force && pwdata[`CSPC_F_REINT]) begin
      cardbus_detected_flag <= card_s2[0] | pwdata[`CSPC_F_CB];
      sixteen_bit_detected_flag <= card_s2[5] | pwdata[`CSPC_F_SIXTEEN];
    end else if (wr_force) begin
      cardbus_detected_flag <= pwdata[`CSPC_F_CB];
      sixteen_bit_detected_flag <= pwdata[`CSPC_F_SIXTEEN];
    end
  end

  // removal and recognition flags move only by forcing in this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unrecognized_card_flag <= 1'b0;
      data_loss_flag <= 1'b0;
    end else if (wr_force) begin
      unrecognized_card_flag <= pwdata[`CSPC_F_UNREC];
      data_loss_flag <= pwdata[`CSPC_F_LOSS];
    end
  end

  // a rejected control write sets the flag; any accepted one clears it again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_supply_request_flag <= 1'b0;
    end else if (wr_ctrl && (vcc_bad || vpp_bad)) begin
      bad_supply_request_flag <= 1'b1;
    end else if (wr_force) begin
      bad_supply_request_flag <= pwdata[`CSPC_F_BADREQ];
    end else if (wr_ctrl) begin
      bad_supply_request_flag <= 1'b0;
    end
  end

  // power event: a read clears it, a force write loads it; the power cycle status is left alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_event_flag <= 1'b0;
    end else if (wr_force) begin
      power_event_flag <= pwdata[`CSPC_F_PWR];
    end else if (rd_event) begin
      power_event_flag <= 1'b0;
    end
  end

  // detect and status events: a read clears them, a force write loads them; the write wins
  // the live levels beside them are the synced pins and never see the forced values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_two_event_flag <= 1'b0;
      detect_one_event_flag <= 1'b0;
      status_change_event_flag <= 1'b0;
    end else if (wr_force) begin
      detect_two_event_flag <= pwdata[`CSPC_F_DET2];
      detect_one_event_flag <= pwdata[`CSPC_F_DET1];
      status_change_event_flag <= pwdata[`CSPC_F_STS];
    end else if (rd_event) begin
      detect_two_event_flag <= 1'b0;
      detect_one_event_flag <= 1'b0;
      status_change_event_flag <= 1'b0;
    end
  end

  // read mux; live levels come from the two-flop synced pins, untouched by forcing
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `CSPC_OFF_FORCE: next_prdata = 32'h0000_0000;
      `CSPC_OFF_CTRL: next_prdata = {24'h00_0000, ctrl[7:4], 1'b0, ctrl[2:0]};
      `CSPC_OFF_PRESENT: next_prdata = {18'h0_0000, volt_flags, bad_supply_request_flag, data_loss_flag,
                                        unrecognized_card_flag, 1'b0, cardbus_detected_flag,
                                        sixteen_bit_detected_flag, pin_s2[5], pin_s2[3], pin_s2[2],
                                        pin_s2[4]};
      `CSPC_OFF_EVENT: next_prdata = {28'h000_0000, power_event_flag, detect_two_event_flag,
                                      detect_one_event_flag, status_change_event_flag};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // read data is caught in the setup cycle so it stands through the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule // cspc_socket
`default_nettype wire

// ---- cspc_cfg.svh ----
`ifndef CSPC_CFG_SVH
`define CSPC_CFG_SVH
// register byte offsets
`define CSPC_OFF_FORCE 12'h00C
`define CSPC_OFF_CTRL 12'h010
`define CSPC_OFF_PRESENT 12'h014
`define CSPC_OFF_EVENT 12'h018
// force-event field positions
`define CSPC_F_REINT 14
`define CSPC_F_YY 13
`define CSPC_F_XX 12
`define CSPC_F_LOW 11
`define CSPC_F_HIGH 10
`define CSPC_F_BADREQ 9
`define CSPC_F_LOSS 8
`define CSPC_F_UNREC 7
`define CSPC_F_CB 5
`define CSPC_F_SIXTEEN 4
`define CSPC_F_PWR 3
`define CSPC_F_DET2 2
`define CSPC_F_DET1 1
`define CSPC_F_STS 0
// socket control fields
`define CSPC_C_STOP 7
`define CSPC_C_VCC_HI 6
`define CSPC_C_VCC_LO 4
`define CSPC_C_VPP_HI 2
`define CSPC_C_VPP_LO 0
`define CSPC_CTRL_RESET 8'h00
// idle clocks before a clock-stop request
`define CSPC_IDLE_CLOCKS 4'h8
`endif

// ---- cspc_pkg.sv ----
`default_nettype none
package cspc_pkg;
  typedef enum logic [2:0] {
    CSPC_VCC_OFF = 3'h0,
    CSPC_VCC_5V0 = 3'h2,
    CSPC_VCC_3V3 = 3'h3,
    CSPC_VCC_XX = 3'h4,
    CSPC_VCC_YY = 3'h5
  } cspc_vcc_t;
  typedef enum logic [2:0] {
    CSPC_VPP_OFF = 3'h0,
    CSPC_VPP_12V = 3'h1,
    CSPC_VPP_5V0 = 3'h2,
    CSPC_VPP_3V3 = 3'h3,
    CSPC_VPP_XX = 3'h4,
    CSPC_VPP_YY = 3'h5
  } cspc_vpp_t;
  typedef enum logic [1:0] {
    CSPC_RUN = 2'b01,
    CSPC_STOP_REQ = 2'b10
  } cspc_clk_state_t;
endpackage
`default_nettype wire

// ---- cspc_idle_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface cspc_idle_if;
  logic policy;
  logic bus_idle;
  logic host_stop_req;
  logic stop_req;
  modport ctl (input policy, input bus_idle, input host_stop_req, output stop_req);
  modport top (output policy, output bus_idle, output host_stop_req, input stop_req);
endinterface
`default_nettype wire

// ---- cspc_clkstop.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cspc_cfg.svh"
module cspc_clkstop (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // idle inputs and request
  cspc_idle_if.ctl idl
);
  logic [3:0] idle_cnt;
  cspc_pkg::cspc_clk_state_t state;
  logic idle_enough;

  assign idle_enough = (idle_cnt == `CSPC_IDLE_CLOCKS);
  assign idl.stop_req = (state == cspc_pkg::CSPC_STOP_REQ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt <= 4'h0;
    end else if (!idl.bus_idle) begin
      idle_cnt <= 4'h0;
    end else if (!idle_enough) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cspc_pkg::CSPC_RUN;
    end else begin
      unique case (state)
        cspc_pkg::CSPC_RUN: begin
          if (idle_enough && idl.bus_idle && (idl.policy || idl.host_stop_req)) begin
            state <= cspc_pkg::CSPC_STOP_REQ;
          end
        end
        cspc_pkg::CSPC_STOP_REQ: begin
          if (!idl.bus_idle || (!idl.policy && !idl.host_stop_req)) begin
            state <= cspc_pkg::CSPC_RUN;
          end
        end
      endcase
    end
  end
endmodule // cspc_clkstop
`default_nettype wire

// ---- cspc_socket_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module cspc_socket_asserts (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // socket side
  input wire logic card_bus_idle,
  input wire logic host_clock_stop_req,
  input wire logic card_clock_stop_req,
  input wire logic [2:0] vcc_apply,
  input wire logic [2:0] vpp_apply,
  input wire logic interrogate_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic pol;
  logic [3:0] idle_n;
  logic [3:0] host_n;
  assign acc = psel && penable;
  // saturating run lengths of the raw pins, so counts never wrap back below eight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol <= 1'b0;
      idle_n <= 4'h0;
      host_n <= 4'h0;
    end else begin
      if (acc && pwrite && paddr == 12'h010) pol <= pwdata[7];
      idle_n <= card_bus_idle ? idle_n + {3'h0, idle_n != 4'hF} : 4'h0;
      host_n <= host_clock_stop_req ? host_n + {3'h0, host_n != 4'hF} : 4'h0;
    end
  end
  intr_pulse_a: assert property (acc && pwrite && paddr == 12'h00C && pwdata[14] |=> interrogate_pulse)
    else $error("no interrogation pulse");
  force_zero_a: assert property (acc && !pwrite && paddr == 12'h00C |-> prdata == 32'h0000_0000)
    else $error("force register read not zero");
  ctrl_rsvd_a: assert property (acc && !pwrite && paddr == 12'h010 |-> prdata[31:8] == 24'h00_0000 && !prdata[3])
    else $error("control reserved bits set");
  vcc_code_a: assert property (vcc_apply != 3'h1 && vcc_apply < 3'h6 && vpp_apply < 3'h6)
    else $error("reserved supply code applied");
  bad_code_a: assert property (acc && pwrite && paddr == 12'h010 && (pwdata[6:4] == 3'h1 || pwdata[6:5] == 2'h3
    || pwdata[2:1] == 2'h3) |-> ##2 vcc_apply == 3'h0 && vpp_apply == 3'h0)
    else $error("power on after bad code");
  stop_cause_a: assert property ($rose(card_clock_stop_req) |-> idle_n >= 4'h8 && (pol || host_n >= 4'h1))
    else $error("clock stop without cause");
  stop_late_a: assert property (pol && idle_n == 4'hC |-> ##[0:4] card_clock_stop_req)
    else $error("clock stop missing");
  stop_drop_a: assert property (!card_bus_idle [*4] |=> !card_clock_stop_req)
    else $error("clock stop while busy");
  cover property (interrogate_pulse);
  cover property ($rose(card_clock_stop_req) && !pol);
  cover property ($rose(card_clock_stop_req) && pol);
endmodule // cspc_socket_asserts
bind cspc_socket cspc_socket_asserts u_cspc_socket_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .card_bus_idle, .host_clock_stop_req, .card_clock_stop_req, .vcc_apply, .vpp_apply,
  .interrogate_pulse);
`default_nettype wire

// ---- cspc_card_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cspc_card_model #(
  parameter logic [3:0] VOLT = 4'b0010,
  parameter logic CARDBUS = 1'b1
) (
  // bench controls
  input wire logic bus_active,
  input wire logic host_want,
  // card and host pins
  output logic [3:0] card_volt_support_pin,
  output logic card_is_cardbus_pin,
  output logic card_is_sixteen_pin,
  output logic detect_one_pin,
  output logic detect_two_pin,
  output logic status_change_pin,
  output logic power_good_pin,
  output logic card_bus_idle,
  output logic host_clock_stop_req
);
  // inserted card: both detects low, status line high, supply good
  assign card_volt_support_pin = VOLT;
  assign card_is_cardbus_pin = CARDBUS;
  assign card_is_sixteen_pin = !CARDBUS;
  assign detect_one_pin = 1'b0;
  assign detect_two_pin = 1'b0;
  assign status_change_pin = 1'b1;
  assign power_good_pin = 1'b1;
  assign card_bus_idle = !bus_active;
  assign host_clock_stop_req = host_want;
endmodule // cspc_card_model
`default_nettype wire

// ---- cspc_socket_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module cspc_socket_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_active, host_want, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] pat [2];
  logic [3:0] card_volt_support_pin;
  logic card_is_cardbus_pin, card_is_sixteen_pin, detect_one_pin, detect_two_pin, status_change_pin;
  logic power_good_pin, card_bus_idle, host_clock_stop_req, card_clock_stop_req, interrogate_pulse;
  logic [2:0] vcc_apply, vpp_apply;
  int bad_count, num_checks, i;
  always #25 pclk = ~pclk;
  cspc_card_model u_cspc_card_model (.bus_active, .host_want, .card_volt_support_pin, .card_is_cardbus_pin,
    .card_is_sixteen_pin, .detect_one_pin, .detect_two_pin, .status_change_pin, .power_good_pin, .card_bus_idle,
    .host_clock_stop_req);
  cspc_socket u_cspc_socket (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .card_volt_support_pin, .card_is_cardbus_pin, .card_is_sixteen_pin, .detect_one_pin,
    .detect_two_pin, .status_change_pin, .power_good_pin, .card_bus_idle, .host_clock_stop_req,
    .card_clock_stop_req, .vcc_apply, .vpp_apply, .interrogate_pulse);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask
  task automatic wait_stop(input logic e);
    int n;
    for (n = 0; n < 30 && card_clock_stop_req !== e; n++) @(posedge pclk);
    check(32'(card_clock_stop_req), 32'(e));
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100_000;
    bad_count++;
    give_verdict();
  end
  initial begin
    pat = '{32'h0000_2B2F, 32'h0000_1495};
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, host_want} = '0;
    bus_active = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h010, 32'h0000_0000);
    rd_chk(12'h00C, 32'h0000_0000);
    rd_chk(12'h020, 32'h0000_0000);
    check(32'(pslverr), 32'h0000_0000);
    apb(1'b1, 12'h010, 32'hFFFF_FFA9);
    rd_chk(12'h010, 32'h0000_00A1);
    check(32'(vcc_apply), 32'h0000_0002);
    check(32'(vpp_apply), 32'h0000_0001);
    // same code in both fields walks every vcc and vpp encoding
    for (i = 0; i < 8; i++) begin
      ok = (i != 1 && i < 6);
      apb(1'b1, 12'h010, 32'(i * 17));
      rd_chk(12'h010, ok ? 32'(i * 17) : 32'h0000_0000);
      check(32'(vcc_apply), ok ? 32'(i) : 32'h0000_0000);
      check(32'(vpp_apply), ok ? 32'(i) : 32'h0000_0000);
      apb(1'b0, 12'h014, 32'h0000_0000);
      check(32'(rd[9]), 32'(!ok));
    end
    apb(1'b0, 12'h018, 32'h0000_0000);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h00C, pat[i]);
      rd_chk(12'h00C, 32'h0000_0000);
      rd_chk(12'h014, (pat[i] & 32'h0000_3FB0) | 32'h0000_0009);
      rd_chk(12'h018, pat[i] & 32'h0000_000F);
    end
    apb(1'b1, 12'h010, 32'h0000_0020);
    repeat (2) @(posedge pclk);
    check(32'(vcc_apply), 32'h0000_0000);
    apb(1'b1, 12'h00C, 32'h0000_4000);
    @(negedge pclk);
    check(32'(interrogate_pulse), 32'h0000_0001);
    repeat (4) @(posedge pclk);
    check(32'(interrogate_pulse), 32'h0000_0000);
    rd_chk(12'h014, 32'h0000_0829);
    // cardbus card that only takes 3.3 V: 5 V refused, 3.3 V applied
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h010, i ? 32'h0000_0033 : 32'h0000_0020);
      repeat (2) @(posedge pclk);
      check(32'(vcc_apply), i ? 32'h0000_0003 : 32'h0000_0000);
    end
    bus_active <= 1'b0;
    repeat (20) @(posedge pclk);
    check(32'(card_clock_stop_req), 32'h0000_0000);
    host_want <= 1'b1;
    wait_stop(1'b1);
    bus_active <= 1'b1;
    wait_stop(1'b0);
    host_want <= 1'b0;
    apb(1'b1, 12'h010, 32'h0000_00B3);
    bus_active <= 1'b0;
    wait_stop(1'b1);
    repeat (8) @(posedge pclk);
    check(32'(card_clock_stop_req), 32'h0000_0001);
    give_verdict();
  end
endmodule // cspc_socket_test
`default_nettype wire
